// ==== rtl/ssar_defines.vh ====
`ifndef SSAR_DEFINES_VH
`define SSAR_DEFINES_VH

// printed offsets are register indexes; byte address is four times
`define SSAR_IDX_W 10
`define SSAR_ADDR_W 12
`define SSAR_IDX_SLOT_CTRL 10'h058
`define SSAR_IDX_SLOT_STS 10'h05a
`define SSAR_IDX_DEV_CAP2 10'h064
`define SSAR_IDX_DEV_CTL2 10'h068
`define SSAR_IDX_DEV_STS2 10'h06a
`define SSAR_IDX_IRQ_STS 10'h080
`define SSAR_IDX_IRQ_MASK 10'h081

// slot status fields
`define SSAR_LSC_BIT 2
`define SSAR_PDC_BIT 3
`define SSAR_CC_BIT 4
`define SSAR_LSS_BIT 5
`define SSAR_PDS_BIT 6
`define SSAR_EIS_BIT 7
`define SSAR_LAC_BIT 8
`define SSAR_LSS_RST 1'h0
`define SSAR_PDS_RST 1'h1

// slot control
`define SSAR_SCTL_W 13
`define SSAR_SCTL_RST 13'h01c0
`define SSAR_SCTL_EIC_BIT 11

// device capabilities / control two
`define SSAR_ALT_ROUTING_FWD_SUPPORTED_BIT 5
`define SSAR_ALT_ROUTING_FWD_ENABLE_BIT 5
`define SSAR_ALT_ROUTING_FWD_SUPPORTED_RST 1'h1
`define SSAR_ALT_ROUTING_FWD_ENABLE_RST 1'h0

// interrupt status / mask layout
`define SSAR_IRQ_W 4
`define SSAR_IRQ_LSC 0
`define SSAR_IRQ_PDC 1
`define SSAR_IRQ_CC 2
`define SSAR_IRQ_LAC 3

`endif

// ==== rtl/ssar_slot_status_regs.v ====
`include "ssar_defines.vh"
`default_nettype none

// Contract
// - latch sensor change sets slot status bit 2; write one clears
// - presence change sets slot status bit 3; write one clears
// - finished slot control command sets bit 4; write one clears
// - command completed already set simply stays set
// - one slot control write with a low-half byte enabled is exactly one command
// - completion waits for all expander transactions of the command
// - bit 5 is live latch sensor, zero closed, resets zero
// - bit 6 is live presence, one present, resets one
// - bit 7 shows interlock engaged when interlock exists
// - link active change sets slot status bit 8; write one clears
// - forwarding supported bit 5 reads one on downstream ports
// - upstream port reads forwarding supported as fixed zero
// - forwarding enable is read-only zero while support is clear
// - enabled forwarding drops device number zero check on conversion
// - upstream port keeps forwarding enable fixed zero
module ssar_slot_status_regs #(
    parameter HAS_INTERLOCK = 1
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [`SSAR_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire is_upstream_in,
    input wire latch_sensor_state_in,
    input wire presence_state_in,
    input wire interlock_state_in,
    input wire link_active_flag_in,
    output reg exp_req_out,
    output reg [`SSAR_SCTL_W-1:0] exp_data_out,
    input wire exp_done_in,
    input wire conv_valid_in,
    input wire [4:0] conv_dev_num_in,
    output reg conv_reject_out,
    output reg alt_routing_fwd_enable_out,
    output wire irq_out
);

    function [`SSAR_ADDR_W-1:0] byte_addr;
        input [`SSAR_IDX_W-1:0] idx;
        begin
            byte_addr = {idx, 2'h0};
        end
    endfunction

    // byte-enable merge of a 16-bit field held in word lane lo or hi
    function [15:0] lane16;
        input [31:0] d;
        input [3:0] be;
        input hi;
        begin
            if (hi)
            begin
                lane16 = {d[31:24] & {8{be[3]}}, d[23:16] & {8{be[2]}}};
            end
            else
            begin
                lane16 = {d[15:8] & {8{be[1]}}, d[7:0] & {8{be[0]}}};
            end
        end
    endfunction

    // merge one slot control write into the old value lane by lane
    function [`SSAR_SCTL_W-1:0] sctl_merge;
        input [`SSAR_SCTL_W-1:0] old;
        input [15:0] d;
        input [1:0] be;
        reg [15:0] keep;
        begin
            keep = {{8{~be[1]}}, {8{~be[0]}}};
            sctl_merge = d[`SSAR_SCTL_W-1:0] |
                (old & keep[`SSAR_SCTL_W-1:0]);
        end
    endfunction

    // sticky flag: a set in the clearing cycle wins
    function sticky;
        input cur;
        input ev;
        input clr;
        begin
            sticky = ev | (cur & ~clr);
        end
    endfunction

    reg latch_sensor_state;
    reg presence_state;
    reg interlock_state;
    reg link_active_prev;
    reg latch_sensor_changed;
    reg presence_changed;
    reg command_completed;
    reg link_active_changed;
    reg [`SSAR_SCTL_W-1:0] slot_control_reg;
    reg cmd_busy;
    reg alt_routing_fwd_enable;
    reg [`SSAR_IRQ_W-1:0] irq_status;
    reg [`SSAR_IRQ_W-1:0] irq_mask;
    reg rd_done;

    // exact decode: any low address bits set miss every register
    wire [`SSAR_ADDR_W-1:0] addr = avs_address_in;
    wire hit_sctl = addr == byte_addr(`SSAR_IDX_SLOT_CTRL);
    wire hit_ssts = addr == byte_addr(`SSAR_IDX_SLOT_STS);
    wire hit_cap2 = addr == byte_addr(`SSAR_IDX_DEV_CAP2);
    wire hit_ctl2 = addr == byte_addr(`SSAR_IDX_DEV_CTL2);
    wire hit_sts2 = addr == byte_addr(`SSAR_IDX_DEV_STS2);
    wire hit_irqs = addr == byte_addr(`SSAR_IDX_IRQ_STS);
    wire hit_irqm = addr == byte_addr(`SSAR_IDX_IRQ_MASK);

    // a second command is stalled on the bus, never merged or dropped,
    // until the expander reports the first one finished
    wire sctl_stall = avs_write_in & hit_sctl & cmd_busy;
    assign avs_waitrequest_out = (avs_read_in & ~rd_done) | sctl_stall;

    wire wr_take = avs_write_in & ~sctl_stall;
    wire [15:0] wr_lo = lane16(avs_writedata_in, avs_byteenable_in, 1'b0);
    // bytes above the low half are status, never part of a command
    wire cmd_start = wr_take & hit_sctl & (|avs_byteenable_in[1:0]);
    wire [`SSAR_SCTL_W-1:0] sctl_new =
        sctl_merge(slot_control_reg, wr_lo, avs_byteenable_in[1:0]);

    // upstream is a strap; forwarding is a downstream feature only
    wire fwd_supported = ~is_upstream_in;

    // change events against the last sampled value; a pin that differs
    // from its reset value raises its flag right after reset release
    wire ev_latch = latch_sensor_state_in != latch_sensor_state;
    wire ev_presence = presence_state_in != presence_state;
    wire ev_link = link_active_flag_in != link_active_prev;
    wire ev_cmd = cmd_busy & exp_done_in;

    wire sts_wr = wr_take & hit_ssts;
    wire [15:0] sts_clr = sts_wr ? wr_lo : 16'h0000;
    wire irqs_wr = wr_take & hit_irqs;
    wire [`SSAR_IRQ_W-1:0] irq_clr =
        irqs_wr ? wr_lo[`SSAR_IRQ_W-1:0] : {`SSAR_IRQ_W{1'b0}};

    // interrupt sources mirror the four change flags
    wire [`SSAR_IRQ_W-1:0] irq_set;
    assign irq_set[`SSAR_IRQ_LSC] = ev_latch;
    assign irq_set[`SSAR_IRQ_PDC] = ev_presence;
    assign irq_set[`SSAR_IRQ_CC] = ev_cmd;
    assign irq_set[`SSAR_IRQ_LAC] = ev_link;

    assign irq_out = |(irq_status & irq_mask);

    // the interlock bit reads zero when no interlock is fitted
    wire [15:0] slot_status_word;
    assign slot_status_word[1:0] = 2'h0;
    assign slot_status_word[`SSAR_LSC_BIT] = latch_sensor_changed;
    assign slot_status_word[`SSAR_PDC_BIT] = presence_changed;
    assign slot_status_word[`SSAR_CC_BIT] = command_completed;
    assign slot_status_word[`SSAR_LSS_BIT] = latch_sensor_state;
    assign slot_status_word[`SSAR_PDS_BIT] = presence_state;
    assign slot_status_word[`SSAR_EIS_BIT] = interlock_state;
    assign slot_status_word[`SSAR_LAC_BIT] = link_active_changed;
    assign slot_status_word[15:9] = 7'h00;

    // interlock control always reads zero
    wire [15:0] slot_control_word =
        {{(16-`SSAR_SCTL_W){1'b0}},
         slot_control_reg & ~(`SSAR_SCTL_W'h1 << `SSAR_SCTL_EIC_BIT)};

    // unmapped addresses and reserved bits read as zero
    reg [31:0] next_readdata;
    always @*
    begin
        next_readdata = 32'h00000000;
        if (hit_sctl)
        begin
            next_readdata = {slot_status_word, slot_control_word};
        end
        else if (hit_ssts)
        begin
            next_readdata = {16'h0000, slot_status_word};
        end
        else if (hit_cap2)
        begin
            next_readdata[`SSAR_ALT_ROUTING_FWD_SUPPORTED_BIT] = fwd_supported;
        end
        else if (hit_ctl2)
        begin
            next_readdata[`SSAR_ALT_ROUTING_FWD_ENABLE_BIT] = alt_routing_fwd_enable;
        end
        else if (hit_sts2)
        begin
            next_readdata = 32'h00000000;
        end
        else if (hit_irqs)
        begin
            next_readdata[`SSAR_IRQ_W-1:0] = irq_status;
        end
        else if (hit_irqm)
        begin
            next_readdata[`SSAR_IRQ_W-1:0] = irq_mask;
        end
    end

    // read: one wait cycle, data captured then presented, so read
    // data always come from a flop at the cost of one cycle
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rd_done <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end
        else
        begin
            rd_done <= avs_read_in & ~rd_done;
            if (avs_read_in & ~rd_done)
            begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    // live sensor sampling; presence starts as card present
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            latch_sensor_state <= `SSAR_LSS_RST;
            presence_state <= `SSAR_PDS_RST;
            interlock_state <= 1'b0;
            link_active_prev <= 1'b0;
        end
        else
        begin
            latch_sensor_state <= latch_sensor_state_in;
            presence_state <= presence_state_in;
            interlock_state <= (HAS_INTERLOCK != 0) &
                interlock_state_in;
            link_active_prev <= link_active_flag_in;
        end
    end

    // sticky change flags: set wins over a same-cycle clear
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            latch_sensor_changed <= 1'b0;
            presence_changed <= 1'b0;
            command_completed <= 1'b0;
            link_active_changed <= 1'b0;
        end
        else
        begin
            latch_sensor_changed <= sticky(latch_sensor_changed, ev_latch,
                sts_clr[`SSAR_LSC_BIT]);
            presence_changed <= sticky(presence_changed, ev_presence,
                sts_clr[`SSAR_PDC_BIT]);
            // a second completion just keeps the flag high
            command_completed <= sticky(command_completed, ev_cmd,
                sts_clr[`SSAR_CC_BIT]);
            link_active_changed <= sticky(link_active_changed, ev_link,
                sts_clr[`SSAR_LAC_BIT]);
        end
    end

    // slot control command: one write starts one expander job
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            slot_control_reg <= `SSAR_SCTL_RST;
            cmd_busy <= 1'b0;
            exp_req_out <= 1'b0;
            exp_data_out <= {`SSAR_SCTL_W{1'b0}};
        end
        else if (cmd_start)
        begin
            // the expander gets the merged word, so one write is one job
            slot_control_reg <= sctl_new;
            exp_data_out <= sctl_new;
            cmd_busy <= 1'b1;
            exp_req_out <= 1'b1;
        end
        else if (ev_cmd)
        begin
            // completion only after the expander says all is done
            cmd_busy <= 1'b0;
            exp_req_out <= 1'b0;
        end
    end

    // forwarding enable: writable only where supported; the forced
    // clear also drops an enable left over from before a strap change
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            alt_routing_fwd_enable <= `SSAR_ALT_ROUTING_FWD_ENABLE_RST;
        end
        else if (~fwd_supported)
        begin
            alt_routing_fwd_enable <= 1'b0;
        end
        else if (wr_take & hit_ctl2 & avs_byteenable_in[0])
        begin
            alt_routing_fwd_enable <= avs_writedata_in[`SSAR_ALT_ROUTING_FWD_ENABLE_BIT];
        end
    end

    // registered enable as the port and the conversion check see it
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            alt_routing_fwd_enable_out <= 1'b0;
        end
        else
        begin
            alt_routing_fwd_enable_out <= alt_routing_fwd_enable &
                fwd_supported;
        end
    end

    // type 1 to type 0 conversion check; it uses the shown enable, so
    // a fresh enable write takes effect one cycle later but never
    // disagrees with what the port reports
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            conv_reject_out <= 1'b0;
        end
        else
        begin
            conv_reject_out <= conv_valid_in & ~alt_routing_fwd_enable_out &
                (conv_dev_num_in != 5'h00);
        end
    end

    // interrupt status: sticky, write one clears, set wins
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            irq_status <= {`SSAR_IRQ_W{1'b0}};
        end
        else
        begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
        end
    end

    // interrupt mask: plain read and write, low lane only
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            irq_mask <= {`SSAR_IRQ_W{1'b0}};
        end
        else if (wr_take & hit_irqm & avs_byteenable_in[0])
        begin
            irq_mask <= avs_writedata_in[`SSAR_IRQ_W-1:0];
        end
    end

endmodule
`default_nettype wire

// ==== tb/ssar_checker_properties.sv ====
`default_nettype none
module ssar_checker (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] avs_address_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic is_upstream_in,
    input wire logic exp_req_out,
    input wire logic exp_done_in,
    input wire logic conv_valid_in,
    input wire logic [4:0] conv_dev_num_in,
    input wire logic conv_reject_out,
    input wire logic alt_routing_fwd_enable_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence ctl_wr;
        avs_write_in && avs_address_in == 12'h160;
    endsequence
    sequence cmd_take;
        ctl_wr ##0 !avs_waitrequest_out && !exp_req_out &&
            avs_byteenable_in[1:0] != 2'h0;
    endsequence
    a_cmd_issue: assert property (
        cmd_take |=> exp_req_out) else $error("command not started");
    a_busy_stall: assert property (
        ctl_wr ##0 exp_req_out && !exp_done_in |-> avs_waitrequest_out)
        else $error("second command not stalled");
    a_cmd_holds: assert property (
        exp_req_out && !exp_done_in |=> exp_req_out)
        else $error("command ended before expander done");
    a_cmd_done: assert property (
        exp_req_out && exp_done_in |=> !exp_req_out)
        else $error("command not retired on done");
    a_fwd_reject: assert property (
        conv_valid_in && conv_dev_num_in != 5'h0 &&
        !alt_routing_fwd_enable_out |=> conv_reject_out)
        else $error("nonzero device not rejected");
    a_fwd_pass: assert property (
        conv_valid_in && (conv_dev_num_in == 5'h0 ||
        alt_routing_fwd_enable_out) |=> !conv_reject_out)
        else $error("request rejected wrongly");
    a_up_enable_off: assert property (
        is_upstream_in [*3] |-> !alt_routing_fwd_enable_out)
        else $error("forwarding enabled on upstream port");
    a_up_no_support: assert property (
        avs_read_in && !avs_waitrequest_out && is_upstream_in &&
        avs_address_in == 12'h190 |-> avs_readdata_out[5] == 1'b0)
        else $error("upstream reports forwarding support");
endmodule
bind ssar_slot_status_regs ssar_checker u_chk (.*);
`default_nettype wire

// ==== tb/ssar_slot_status_regs_tb.sv ====
`default_nettype none
module ssar_slot_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in, rst_in, avs_read_in, avs_write_in, is_upstream_in;
    logic latch_sensor_state_in, presence_state_in, interlock_state_in;
    logic link_active_flag_in, exp_done_in, conv_valid_in, exp_req_out;
    logic avs_waitrequest_out, conv_reject_out, irq_out;
    logic alt_routing_fwd_enable_out;
    logic [11:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q, e;
    logic [3:0] avs_byteenable_in, s, p;
    logic [4:0] conv_dev_num_in;
    logic [12:0] exp_data_out;
    logic [3:0] tbl [4] = '{4'h3, 4'h1, 4'h5, 4'hd};
    int n_fail, num_checks;
    ssar_slot_status_regs dut (.*);
    initial
    begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic r, input logic [11:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_read_in <= r;
        avs_write_in <= !r;
        avs_writedata_in <= d;
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] x);
        bus(1'b1, a, 32'h0);
        chk("register", q, x);
    endtask
    task cv(input logic [4:0] n, input logic x);
        conv_valid_in <= 1'b1;
        conv_dev_num_in <= n;
        @(posedge sys_clk_in);
        conv_valid_in <= 1'b0;
        #1 chk("reject", {31'h0, conv_reject_out}, {31'h0, x});
        @(posedge sys_clk_in);
    endtask
    task pulse_done;
        exp_done_in <= 1'b1;
        @(posedge sys_clk_in);
        exp_done_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge sys_clk_in);
        n_fail++;
        end_sim;
    end
    initial
    begin
        {avs_read_in, avs_write_in, is_upstream_in, exp_done_in} = 4'h0;
        {latch_sensor_state_in, interlock_state_in} = 2'h0;
        {link_active_flag_in, conv_valid_in} = 2'h0;
        presence_state_in = 1'b1;
        avs_address_in = 12'h0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hf;
        conv_dev_num_in = 5'h0;
        rst_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rdc(12'h168, 32'h40);
        rdc(12'h190, 32'h20);
        rdc(12'h1a0, 32'h0);
        rdc(12'h1a8, 32'h0);
        rdc(12'h3fc, 32'h0);
        $display("reset values done");
        bus(1'b0, 12'h204, 32'hf);
        p = 4'h2;
        for (int i = 0; i < 4; i++)
        begin
            s = tbl[i];
            link_active_flag_in <= s[3];
            interlock_state_in <= s[2];
            presence_state_in <= s[1];
            latch_sensor_state_in <= s[0];
            repeat (3) @(posedge sys_clk_in);
            e = {s[2:0], 5'h0} | {s[3] ^ p[3], 4'h0, s[1:0] ^ p[1:0], 2'h0};
            rdc(12'h168, e);
            chk("irq", {31'h0, irq_out}, {31'h0, |((s ^ p) & 4'hb)});
            bus(1'b0, 12'h168, 32'h0);
            rdc(12'h168, e);
            bus(1'b0, 12'h168, 32'h10c);
            bus(1'b0, 12'h200, 32'hf);
            rdc(12'h168, e & 32'he0);
            chk("irq", {31'h0, irq_out}, 32'h0);
            p = s;
        end
        $display("sensor flags done");
        bus(1'b0, 12'h204, 32'h0);
        bus(1'b0, 12'h160, 32'h3);
        chk("req", {31'h0, exp_req_out}, 32'h1);
        chk("data", {19'h0, exp_data_out}, 32'h3);
        fork
            bus(1'b0, 12'h160, 32'h5);
            begin
                repeat (3) @(posedge sys_clk_in);
                exp_done_in <= 1'b1;
                @(posedge sys_clk_in);
                exp_done_in <= 1'b0;
            end
        join
        chk("data", {19'h0, exp_data_out}, 32'h5);
        rdc(12'h168, 32'hb0);
        chk("irq", {31'h0, irq_out}, 32'h0);
        bus(1'b0, 12'h204, 32'h4);
        chk("irq", {31'h0, irq_out}, 32'h1);
        exp_done_in <= 1'b1;
        @(posedge sys_clk_in);
        exp_done_in <= 1'b0;
        @(posedge sys_clk_in);
        chk("req", {31'h0, exp_req_out}, 32'h0);
        rdc(12'h168, 32'hb0);
        bus(1'b0, 12'h168, 32'h10);
        rdc(12'h168, 32'ha0);
        bus(1'b0, 12'h200, 32'h4);
        chk("irq", {31'h0, irq_out}, 32'h0);
        bus(1'b0, 12'h160, 32'h1803);
        chk("data", {19'h0, exp_data_out}, 32'h1803);
        pulse_done;
        chk("irq", {31'h0, irq_out}, 32'h1);
        rdc(12'h160, 32'h00b01003);
        bus(1'b0, 12'h160, 32'h3);
        pulse_done;
        rdc(12'h160, 32'h00b00003);
        bus(1'b0, 12'h168, 32'h10);
        bus(1'b0, 12'h200, 32'h4);
        $display("command tracking done");
        bus(1'b0, 12'h1a0, 32'h20);
        rdc(12'h1a0, 32'h20);
        repeat (2) @(posedge sys_clk_in);
        chk("enable", {31'h0, alt_routing_fwd_enable_out}, 32'h1);
        cv(5'h3, 1'b0);
        bus(1'b0, 12'h1a0, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        chk("enable", {31'h0, alt_routing_fwd_enable_out}, 32'h0);
        cv(5'h3, 1'b1);
        cv(5'h0, 1'b0);
        bus(1'b0, 12'h1a0, 32'h20);
        is_upstream_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rdc(12'h190, 32'h0);
        rdc(12'h1a0, 32'h0);
        chk("enable", {31'h0, alt_routing_fwd_enable_out}, 32'h0);
        bus(1'b0, 12'h1a0, 32'h20);
        rdc(12'h1a0, 32'h0);
        cv(5'h3, 1'b1);
        $display("forwarding done");
        end_sim;
    end
endmodule
`default_nettype wire
